// ==== inc/essr_pkg.sv ====
// essr_pkg: save-area layout, register map, init values and sequencer states
// assumes a byte-addressed save area seen through 64-bit little-endian words
package essr_pkg;
   // save-area byte offsets
   localparam logic [9:0] LEGACY_BYTES = 10'h200;
   localparam logic [9:0] HDR_OFS      = LEGACY_BYTES;
   localparam logic [9:0] WIDE_OFS     = 10'h240;
   // image word indices (byte offset / 8)
   localparam logic [6:0] W_FPU      = 7'h00;
   localparam logic [6:0] W_FIP      = 7'h01;
   localparam logic [6:0] W_FDP      = 7'h02;
   localparam logic [6:0] W_MX       = 7'h03;
   localparam logic [6:0] W_ST       = 7'h04;
   localparam logic [6:0] W_ST_END   = 7'h13;
   localparam logic [6:0] W_XMM      = 7'h14;
   localparam logic [6:0] W_XMM_END  = 7'h33;
   localparam logic [6:0] W_HDR      = HDR_OFS[9:3];
   localparam logic [6:0] W_WIDE     = WIDE_OFS[9:3];
   localparam logic [6:0] W_LAST     = 7'h67;
   // component bit positions
   localparam int unsigned BIT_FPU   = 0;
   localparam int unsigned BIT_VEC   = 1;
   localparam int unsigned BIT_WIDE  = 2;
   localparam int unsigned FSW_ES    = 7;
   // hardware initial values and reset values
   localparam logic [15:0] FCW_INIT   = 16'h037f;
   localparam logic [15:0] FSW_INIT   = 16'h0000;
   localparam logic [7:0]  FTW_INIT   = 8'h00;
   localparam logic [63:0] FPU_INIT_WORD = {16'h0000, 8'h00, FTW_INIT, FSW_INIT, FCW_INIT};
   localparam logic [31:0] MX_SUPPORT = 32'h0000_ffbf;
   localparam logic [31:0] MX_RESET   = 32'h0000_1f80;
   localparam logic [2:0]  FEAT_RESET = 3'h1;
   // register port addresses
   localparam logic [7:0] A_FEAT   = 8'h00;
   localparam logic [7:0] A_IMASK  = 8'h01;
   localparam logic [7:0] A_MODE   = 8'h02;
   localparam logic [7:0] A_CMD    = 8'h03;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_HDR    = 8'h05;
   localparam int unsigned A_IMAGE_BIT = 7;
   // commands
   localparam logic [1:0] CMD_STORE     = 2'h1;
   localparam logic [1:0] CMD_LOAD      = 2'h2;
   localparam logic [1:0] CMD_STORE_OPT = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_HDR_RD   = 3'b001,
      ST_HDR_WAIT = 3'b011,
      ST_HDR_USE  = 3'b010,
      ST_RUN      = 3'b110,
      ST_DRAIN    = 3'b111
   } essr_state_e;
endpackage

// ==== logic/essr_core.sv ====
// essr_core: extended state store/load sequencer with the architectural state
// assumes memory answers a read one cycle after mem_re_o and never stalls
`timescale 1ns/1ns
module essr_core
(
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [63:0] reg_wdata_i,
   input  wire logic        reg_we_i,
   input  wire logic        reg_re_i,
   output logic      [63:0] reg_rdata_o,
   output logic      [9:0]  mem_addr_o,
   output logic      [63:0] mem_wdata_o,
   output logic             mem_we_o,
   output logic             mem_re_o,
   input  wire logic [63:0] mem_rdata_i,
   output logic             busy_o,
   output logic             done_o
);

   typedef struct packed {
      essr_pkg::essr_state_e state;
      logic                  op_load;
      logic [2:0]            sel;
      logic [6:0]            word;
      logic                  long_mode;
      logic [2:0]            feat;
      logic [2:0]            imask;
      logic                  wr_err;
      logic [63:0]           bv;
      logic [15:0]           fpu_control_word;
      logic [15:0]           fpu_status_word;
      logic [7:0]            fpu_tag_word;
      logic [15:0]           fop;
      logic [63:0]           fip;
      logic [63:0]           fdp;
      logic [31:0]           media_control_status;
      logic [7:0][79:0]      st;
      logic [15:0][127:0]    vector_128_component;
      logic [15:0][127:0]    wide;
      logic                  re_d;
      logic [6:0]            cap_word;
      logic [9:0]            mem_addr;
      logic [63:0]           mem_wdata;
      logic                  mem_we;
      logic                  mem_re;
      logic [63:0]           rdata;
      logic                  busy;
      logic                  done;
   } essr_regs_s;

   essr_regs_s s_reg;
   essr_regs_s s_next;

   ////////////////////////////////////////////////////////////////////////////////
   // image word access

   function automatic logic [3:0] pair_idx(input logic [6:0] w, input logic [6:0] base);
      logic [6:0] off;
      off = w - base;
      return off[4:1];
   endfunction

   // legacy image layout, 64-bit form
   function automatic logic [63:0] get_word(input essr_regs_s x, input logic [6:0] w);
      logic [3:0] i;
      logic [63:0] d;
      d = '0;
      i = 4'h0;
      if (w == essr_pkg::W_FPU)
         d = {x.fop, 8'h00, x.fpu_tag_word, x.fpu_status_word, x.fpu_control_word};
      else if (w == essr_pkg::W_FIP)
         d = x.fip;
      else if (w == essr_pkg::W_FDP)
         d = x.fdp;
      else if (w == essr_pkg::W_MX)
         d = {essr_pkg::MX_SUPPORT, x.media_control_status};
      else if (w >= essr_pkg::W_ST && w <= essr_pkg::W_ST_END) begin
         i = pair_idx(w, essr_pkg::W_ST);
         d = w[0] ? {48'h0000_0000_0000, x.st[i[2:0]][79:64]} : x.st[i[2:0]][63:0];
      end
      else if (w >= essr_pkg::W_XMM && w <= essr_pkg::W_XMM_END) begin
         i = pair_idx(w, essr_pkg::W_XMM);
         d = w[0] ? x.vector_128_component[i][127:64] : x.vector_128_component[i][63:0];
      end
      else if (w >= essr_pkg::W_WIDE && w <= essr_pkg::W_LAST) begin
         i = pair_idx(w, essr_pkg::W_WIDE);
         d = w[0] ? x.wide[i][127:64] : x.wide[i][63:0];
      end
      return d;
   endfunction

   function automatic essr_regs_s put_word(input essr_regs_s x, input logic [6:0] w,
                                           input logic [63:0] d);
      essr_regs_s y;
      logic [3:0] i;
      y = x;
      i = 4'h0;
      if (w == essr_pkg::W_FPU) begin
         y.fpu_control_word = d[15:0];
         y.fpu_status_word = d[31:16];
         y.fpu_tag_word = d[39:32];
         y.fop = d[63:48];
      end
      else if (w == essr_pkg::W_FIP)
         y.fip = d;
      else if (w == essr_pkg::W_FDP)
         y.fdp = d;
      else if (w == essr_pkg::W_MX)
         y.media_control_status = d[31:0] & essr_pkg::MX_SUPPORT;
      else if (w >= essr_pkg::W_ST && w <= essr_pkg::W_ST_END) begin
         i = pair_idx(w, essr_pkg::W_ST);
         if (w[0])
            y.st[i[2:0]][79:64] = d[15:0];
         else
            y.st[i[2:0]][63:0] = d;
      end
      else if (w >= essr_pkg::W_XMM && w <= essr_pkg::W_XMM_END) begin
         i = pair_idx(w, essr_pkg::W_XMM);
         if (w[0])
            y.vector_128_component[i][127:64] = d;
         else
            y.vector_128_component[i][63:0] = d;
      end
      else if (w >= essr_pkg::W_WIDE && w <= essr_pkg::W_LAST) begin
         i = pair_idx(w, essr_pkg::W_WIDE);
         if (w[0])
            y.wide[i][127:64] = d;
         else
            y.wide[i][63:0] = d;
      end
      return y;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // per-word classification of the visited word

   logic [6:0] w;
   logic [3:0] reg_idx;
   logic       hit;
   logic       is_ptr;
   logic       is_mx;
   logic       in_rng;
   logic [1:0] comp;
   logic       enabled;
   logic       present;
   logic [2:0] sel_new;
   logic [63:0] sel64;

   always_comb
   begin
      w       = s_reg.word;
      reg_idx = 4'h0;
      hit     = 1'b1;
      in_rng  = 1'b1;
      comp    = 2'(essr_pkg::BIT_FPU);
      is_ptr  = (w == essr_pkg::W_FIP) || (w == essr_pkg::W_FDP);
      is_mx   = (w == essr_pkg::W_MX);
      if (w == essr_pkg::W_FPU || is_ptr)
         comp = 2'(essr_pkg::BIT_FPU);
      else if (is_mx)
         comp = 2'(essr_pkg::BIT_VEC);
      else if (w >= essr_pkg::W_ST && w <= essr_pkg::W_ST_END)
         comp = 2'(essr_pkg::BIT_VEC);
      else if (w >= essr_pkg::W_XMM && w <= essr_pkg::W_XMM_END) begin
         comp    = 2'(essr_pkg::BIT_VEC);
         reg_idx = pair_idx(w, essr_pkg::W_XMM);
         in_rng  = s_reg.long_mode || !reg_idx[3];
      end
      else if (w >= essr_pkg::W_WIDE && w <= essr_pkg::W_LAST) begin
         comp    = 2'(essr_pkg::BIT_WIDE);
         reg_idx = pair_idx(w, essr_pkg::W_WIDE);
         in_rng  = s_reg.long_mode || !reg_idx[3];
      end
      else
         hit = 1'b0;
      // media control follows either vector component
      enabled = is_mx ? (s_reg.sel[essr_pkg::BIT_VEC] | s_reg.sel[essr_pkg::BIT_WIDE])
                      : s_reg.sel[comp];
      present = is_mx | s_reg.bv[comp];
      sel_new = s_reg.imask & s_reg.feat;
      sel64   = {61'h0, s_reg.sel};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      s_next          = s_reg;
      s_next.done     = 1'b0;
      s_next.mem_we   = 1'b0;
      s_next.mem_re   = 1'b0;
      s_next.rdata    = '0;
      s_next.re_d     = s_reg.mem_re;
      s_next.cap_word = s_reg.mem_addr[9:3];

      // read data of the word requested one cycle ago
      if (s_reg.re_d && s_reg.cap_word != essr_pkg::W_HDR) begin
         if (!((s_reg.cap_word == essr_pkg::W_FIP || s_reg.cap_word == essr_pkg::W_FDP)
               && !s_reg.fpu_status_word[essr_pkg::FSW_ES]))
            s_next = put_word(s_next, s_reg.cap_word, mem_rdata_i);
      end

      if (reg_re_i) begin
         if (reg_addr_i[essr_pkg::A_IMAGE_BIT])
            s_next.rdata = get_word(s_reg, reg_addr_i[6:0]);
         else
            case (reg_addr_i)
               essr_pkg::A_FEAT:   s_next.rdata = {61'h0, s_reg.feat};
               essr_pkg::A_IMASK:  s_next.rdata = {61'h0, s_reg.imask};
               essr_pkg::A_MODE:   s_next.rdata = {63'h0, s_reg.long_mode};
               essr_pkg::A_STATUS: s_next.rdata = {62'h0, s_reg.wr_err, s_reg.busy};
               essr_pkg::A_HDR:    s_next.rdata = s_reg.bv;
               default:            s_next.rdata = '0;
            endcase
      end

      if (reg_we_i && !s_reg.busy) begin
         if (reg_addr_i[essr_pkg::A_IMAGE_BIT])
            s_next = put_word(s_next, reg_addr_i[6:0], reg_wdata_i);
         else
            case (reg_addr_i)
               essr_pkg::A_FEAT:
               begin
                  // illegal masks are dropped and flagged
                  if (reg_wdata_i[63:3] == 61'h0 && reg_wdata_i[0]
                      && reg_wdata_i[2:1] != 2'b10) begin
                     s_next.feat   = reg_wdata_i[2:0];
                     s_next.wr_err = 1'b0;
                  end
                  else
                     s_next.wr_err = 1'b1;
               end
               essr_pkg::A_IMASK: s_next.imask     = reg_wdata_i[2:0];
               essr_pkg::A_MODE:  s_next.long_mode = reg_wdata_i[0];
               essr_pkg::A_CMD:
               begin
                  s_next.sel  = sel_new;
                  s_next.word = essr_pkg::W_FPU;
                  if (reg_wdata_i[1:0] == essr_pkg::CMD_LOAD) begin
                     s_next.op_load = 1'b1;
                     s_next.busy    = 1'b1;
                     s_next.state   = essr_pkg::ST_HDR_RD;
                  end
                  else if (reg_wdata_i[1:0] == essr_pkg::CMD_STORE
                           || reg_wdata_i[1:0] == essr_pkg::CMD_STORE_OPT) begin
                     s_next.op_load = 1'b0;
                     s_next.busy    = 1'b1;
                     s_next.state   = essr_pkg::ST_RUN;
                  end
               end
               default: ;
            endcase
      end

      case (s_reg.state)
         essr_pkg::ST_IDLE: ;
         essr_pkg::ST_HDR_RD:
         begin
            s_next.mem_re   = 1'b1;
            s_next.mem_addr = essr_pkg::HDR_OFS;
            s_next.state    = essr_pkg::ST_HDR_WAIT;
         end
         essr_pkg::ST_HDR_WAIT:
            s_next.state = essr_pkg::ST_HDR_USE;
         essr_pkg::ST_HDR_USE:
         begin
            if (s_reg.op_load) begin
               s_next.bv    = mem_rdata_i;
               s_next.state = essr_pkg::ST_RUN;
            end
            else begin
               s_next.bv        = (mem_rdata_i & ~sel64) | sel64;
               s_next.mem_we    = 1'b1;
               s_next.mem_addr  = essr_pkg::HDR_OFS;
               s_next.mem_wdata = (mem_rdata_i & ~sel64) | sel64;
               s_next.busy      = 1'b0;
               s_next.done      = 1'b1;
               s_next.state     = essr_pkg::ST_IDLE;
            end
         end
         essr_pkg::ST_RUN:
         begin
            if (hit && enabled && in_rng) begin
               if (!s_reg.op_load) begin
                  if (!is_ptr || s_reg.fpu_status_word[essr_pkg::FSW_ES]) begin
                     s_next.mem_we    = 1'b1;
                     s_next.mem_addr  = {w, 3'b000};
                     s_next.mem_wdata = get_word(s_reg, w);
                  end
               end
               else if (present) begin
                  s_next.mem_re   = 1'b1;
                  s_next.mem_addr = {w, 3'b000};
               end
               else
                  s_next = put_word(s_next, w,
                     (w == essr_pkg::W_FPU) ? essr_pkg::FPU_INIT_WORD : 64'h0);
            end
            s_next.word = w + 7'h01;
            if (w == essr_pkg::W_LAST)
               s_next.state = s_reg.op_load ? essr_pkg::ST_DRAIN : essr_pkg::ST_HDR_RD;
         end
         essr_pkg::ST_DRAIN:
         begin
            if (!s_reg.mem_re) begin
               s_next.busy  = 1'b0;
               s_next.done  = 1'b1;
               s_next.state = essr_pkg::ST_IDLE;
            end
         end
         default:
            s_next.state = essr_pkg::ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i) begin
         s_reg       <= '0;
         s_reg.state <= essr_pkg::ST_IDLE;
         s_reg.feat  <= essr_pkg::FEAT_RESET;
         s_reg.fpu_control_word   <= essr_pkg::FCW_INIT;
         s_reg.media_control_status <= essr_pkg::MX_RESET;
      end
      else
         s_reg <= s_next;
   end

   assign reg_rdata_o = s_reg.rdata;
   assign mem_addr_o  = s_reg.mem_addr;
   assign mem_wdata_o = s_reg.mem_wdata;
   assign mem_we_o    = s_reg.mem_we;
   assign mem_re_o    = s_reg.mem_re;
   assign busy_o      = s_reg.busy;
   assign done_o      = s_reg.done;

endmodule // essr_core

// ==== sim/essr_core_checker.sv ====
// essr_core_checker: port-level assertions for the state save/load sequencer
// assumes the register and memory timing of the sequencer hand-over
`timescale 1ns/1ns
module essr_core_checker
(
   input wire logic        clock_i,
   input wire logic        reset_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [63:0] reg_wdata_i,
   input wire logic        reg_we_i,
   input wire logic        reg_re_i,
   input wire logic [63:0] reg_rdata_o,
   input wire logic [9:0]  mem_addr_o,
   input wire logic [63:0] mem_wdata_o,
   input wire logic        mem_we_o,
   input wire logic        mem_re_o,
   input wire logic [63:0] mem_rdata_i,
   input wire logic        busy_o,
   input wire logic        done_o
);
   logic      mode_q;
   wire logic mem_acc = mem_we_o || mem_re_o;
   wire logic hdr_wr  = mem_we_o && (mem_addr_o == essr_pkg::HDR_OFS);
   wire logic cmd_wr  = reg_we_i && !busy_o && (reg_addr_i == essr_pkg::A_CMD);

   // mode copy; writes are refused while busy
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
         mode_q <= 1'b0;
      else if (reg_we_i && !busy_o && reg_addr_i == essr_pkg::A_MODE)
         mode_q <= reg_wdata_i[0];
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   ////////////////////////////////////////////////////////////////////////////
   a_rdata_quiet: assert property (!$past(reg_re_i) |-> reg_rdata_o == 64'h0)
      else $error("read data outside its cycle");
   a_cmd_starts: assert property (cmd_wr && reg_wdata_i inside {64'h1, 64'h2, 64'h3} |=> busy_o)
      else $error("command did not start");
   a_done_falls: assert property (done_o |-> !busy_o && $past(busy_o))
      else $error("done without busy falling");
   a_idle_quiet: assert property (!busy_o && !done_o |-> !mem_acc)
      else $error("memory access while idle");
   a_hdr_rmw: assert property (hdr_wr |-> $past(mem_re_o, 2) && ((mem_wdata_o >> 3) == ($past(mem_rdata_i) >> 3)))
      else $error("header write disturbs unselected bits");
   a_load_hdr_first: assert property ($rose(busy_o) && $past(reg_wdata_i) == 64'h2 |-> ##1 mem_re_o && mem_addr_o == essr_pkg::HDR_OFS)
      else $error("load did not read header first");
   a_store_hdr_last: assert property ($rose(busy_o) && $past(reg_wdata_i) != 64'h2 |-> ##[100:110] hdr_wr && done_o)
      else $error("store did not end with header write");
   a_narrow_mode: assert property (mem_acc && !mode_q |-> !(mem_addr_o inside {[10'h120:10'h19f], [10'h2c0:10'h33f]}))
      else $error("upper registers touched outside 64-bit mode");
   a_word_align: assert property (mem_acc |-> mem_addr_o[2:0] == 3'b000 && mem_addr_o <= 10'h338)
      else $error("memory address outside save area");

   c_store: cover property (hdr_wr && done_o);
   c_load: cover property (done_o && !mem_we_o);
   c_narrow: cover property (mem_acc && !mode_q);
endmodule // essr_core_checker

bind essr_core essr_core_checker u_chk (.clock_i(clock_i), .reset_i(reset_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
   .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o),
   .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o),
   .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o));

// ==== sim/essr_mem_model.sv ====
// essr_mem_model: save-area memory, one word per cycle, read data next cycle
// assumes byte addresses on 8-byte boundaries; data line garbled when idle
`timescale 1ns/1ns
module essr_mem_model
(
   input  wire logic        clock_i,
   input  wire logic [9:0]  mem_addr_i,
   input  wire logic [63:0] mem_wdata_i,
   input  wire logic        mem_we_i,
   input  wire logic        mem_re_i,
   output logic      [63:0] mem_rdata_o
);
   logic [63:0] mem [0:127];
   logic [63:0] last = 64'h0;
   logic        rd_q = 1'b0;

   always @(posedge clock_i)
   begin
      rd_q <= mem_re_i;
      if (mem_we_i)
         mem[mem_addr_i[9:3]] <= mem_wdata_i;
      if (mem_re_i)
         last <= mem[mem_addr_i[9:3]];
   end
   // only the cycle after a read carries data
   assign mem_rdata_o = rd_q ? last : ~last;
endmodule // essr_mem_model

// ==== sim/tb_top.sv ====
// tb_top: register-level tests of the state save/load sequencer
// assumes the memory model answers every read on the following cycle
`timescale 1ns/1ns
module tb_top;
   logic        clock_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [63:0] reg_wdata_i = 64'h0;
   logic        reg_we_i = 1'b0;
   logic        reg_re_i = 1'b0;
   logic [63:0] reg_rdata_o;
   logic [9:0]  mem_addr_o;
   logic [63:0] mem_wdata_o;
   logic        mem_we_o;
   logic        mem_re_o;
   logic [63:0] mem_rdata_i;
   logic        busy_o;
   logic        done_o;
   int          errors = 0;
   int          total_checks = 0;
   int          cycles = 0;
   logic [63:0] bad [3] = '{64'h2, 64'h5, 64'h9};

   always #50 clock_i = ~clock_i;

   essr_core u_dut (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
      .reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
      .mem_we_o(mem_we_o), .mem_re_o(mem_re_o), .mem_rdata_i(mem_rdata_i),
      .busy_o(busy_o), .done_o(done_o));
   essr_mem_model u_mem (.clock_i(clock_i), .mem_addr_i(mem_addr_o),
      .mem_wdata_i(mem_wdata_o), .mem_we_i(mem_we_o), .mem_re_i(mem_re_o),
      .mem_rdata_o(mem_rdata_i));

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [63:0] d);
      @(posedge clock_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_we_i    <= 1'b1;
      @(posedge clock_i);
      reg_we_i    <= 1'b0;
   endtask

   // read, then compare the word standing in the following cycle
   task automatic rc(input logic [7:0] a, input logic [63:0] e);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_re_i   <= 1'b1;
      @(posedge clock_i);
      reg_re_i   <= 1'b0;
      #1 chk(reg_rdata_o, e);
   endtask

   task automatic wait_done;
      int n;
      n = 0;
      while (done_o !== 1'b1 && n < 300)
      begin
         @(posedge clock_i);
         #1 n++;
      end
      chk({63'h0, done_o}, 64'h1);
      // header write lands one edge after done
      @(posedge clock_i);
      #1;
   endtask

   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge clock_i);
      reset_i <= 1'b0;
      rc(essr_pkg::A_FEAT, 64'h1);
      rc(8'h80, essr_pkg::FPU_INIT_WORD);
      rc(8'h83, {essr_pkg::MX_SUPPORT, essr_pkg::MX_RESET});
      rc(8'h10, 64'h0);
      foreach (bad[i])
      begin
         wr(essr_pkg::A_FEAT, bad[i]);
         rc(essr_pkg::A_FEAT, 64'h1);
         rc(essr_pkg::A_STATUS, 64'h2);
      end
      wr(essr_pkg::A_FEAT, 64'h7);
      rc(essr_pkg::A_FEAT, 64'h7);
      rc(essr_pkg::A_STATUS, 64'h0);
      // full store in 64-bit mode, no pending exception
      wr(essr_pkg::A_MODE, 64'h1);
      wr(essr_pkg::A_IMASK, 64'h7);
      wr(8'h81, 64'hf1f1);
      wr(8'ha4, 64'h1234);
      wr(8'hd8, 64'h5678);
      u_mem.mem[1] = 64'haaaa;
      u_mem.mem[64] = 64'hffff_0000_0000_0000;
      wr(essr_pkg::A_CMD, 64'h1);
      wr(essr_pkg::A_IMASK, 64'h0);
      rc(essr_pkg::A_STATUS, 64'h1);
      wait_done();
      chk(u_mem.mem[64], 64'hffff_0000_0000_0007);
      chk(u_mem.mem[1], 64'haaaa);
      chk(u_mem.mem[36], 64'h1234);
      chk(u_mem.mem[88], 64'h5678);
      chk({32'h0, u_mem.mem[3][31:0]}, {32'h0, essr_pkg::MX_RESET});
      rc(essr_pkg::A_IMASK, 64'h7);
      rc(essr_pkg::A_HDR, 64'hffff_0000_0000_0007);
      rc(essr_pkg::A_MODE, 64'h1);
      // optimized store, partial mask, narrow mode
      wr(essr_pkg::A_MODE, 64'h0);
      wr(essr_pkg::A_IMASK, 64'h3);
      u_mem.mem[64] = 64'h8;
      u_mem.mem[20] = 64'hbeef;
      u_mem.mem[36] = 64'hbeef;
      u_mem.mem[72] = 64'hcafe;
      wr(essr_pkg::A_CMD, 64'h3);
      wait_done();
      chk(u_mem.mem[64], 64'hb);
      chk(u_mem.mem[20], 64'h0);
      chk(u_mem.mem[36], 64'hbeef);
      chk(u_mem.mem[72], 64'hcafe);
      // load, float present with pending exception, narrow mode
      wr(essr_pkg::A_IMASK, 64'h7);
      wr(8'h94, 64'h11);
      wr(8'hc8, 64'h33);
      u_mem.mem[64] = 64'h1;
      u_mem.mem[0] = 64'h0080_0abc;
      u_mem.mem[1] = 64'h4444;
      u_mem.mem[2] = 64'h5555;
      u_mem.mem[3] = 64'h9f80;
      wr(essr_pkg::A_CMD, 64'h2);
      wait_done();
      rc(8'h80, 64'h0080_0abc);
      rc(8'h81, 64'h4444);
      rc(8'h82, 64'h5555);
      rc(8'h83, {essr_pkg::MX_SUPPORT, 32'h0000_9f80});
      rc(8'h94, 64'h0);
      rc(8'ha4, 64'h1234);
      rc(8'hc8, 64'h0);
      rc(8'hd8, 64'h5678);
      // load without float selected, 64-bit mode, nothing present
      wr(essr_pkg::A_MODE, 64'h1);
      wr(essr_pkg::A_IMASK, 64'h6);
      u_mem.mem[64] = 64'h0;
      u_mem.mem[3] = 64'h1fc0;
      wr(essr_pkg::A_CMD, 64'h2);
      wait_done();
      rc(8'h80, 64'h0080_0abc);
      rc(8'ha4, 64'h0);
      rc(8'hd8, 64'h0);
      rc(8'h83, {essr_pkg::MX_SUPPORT, 32'h0000_1f80});
      // load of absent float component
      wr(essr_pkg::A_IMASK, 64'h1);
      wr(essr_pkg::A_CMD, 64'h2);
      wait_done();
      rc(8'h80, essr_pkg::FPU_INIT_WORD);
      rc(8'h81, 64'h0);
      end_sim();
   end
endmodule // tb_top
